/* hdl/adccf_map.vh */
`ifndef ADCCF_MAP_VH
`define ADCCF_MAP_VH

// Register byte offsets
`define ADCCF_OFS_CTRL_B       8'h03
`define ADCCF_OFS_RESULT_LOW   8'h04
`define ADCCF_OFS_RESULT_HIGH  8'h05
`define ADCCF_OFS_CTRL_A       8'h06
`define ADCCF_OFS_MUX_SELECT   8'h07

// control_status_a fields
`define ADCCF_A_ENABLE         7
`define ADCCF_A_START          6
`define ADCCF_A_AUTO           5
`define ADCCF_A_DONE           4
`define ADCCF_A_IRQ_EN         3
`define ADCCF_A_DIV_HI         2
`define ADCCF_A_DIV_LO         0

// control_status_b fields
`define ADCCF_B_BIPOLAR        7
`define ADCCF_B_CHAN_HI        3
`define ADCCF_B_TRIG_HI        2
`define ADCCF_B_TRIG_LO        0

// mux_select_reg fields
`define ADCCF_M_LEFT_ALIGN     5
`define ADCCF_M_CHAN_HI        4
`define ADCCF_M_CHAN_LO        0

// Reset values
`define ADCCF_RST_CTRL_A       8'h00
`define ADCCF_RST_CTRL_B       8'h00
`define ADCCF_RST_MUX          8'h00
`define ADCCF_RST_RESULT       10'h000

// Converter clock cycles per conversion
`define ADCCF_CYC_FIRST        5'h19
`define ADCCF_CYC_NORMAL       5'h0D

// Special codes
`define ADCCF_TEMP_CHANNEL     6'h3F
`define ADCCF_TRIG_FREE_RUN    3'h0
`define ADCCF_CODE_MAX         10'h3FF
`define ADCCF_CODE_MIN         10'h000
`define ADCCF_BIP_MAX          10'h1FF
`define ADCCF_BIP_MIN          10'h200

`endif

/* hdl/adccf_prescaler.v */
`timescale 1ns/1ns
module adccf_prescaler
(
  input  wire       core_clk,
  input  wire       rst_n,
  input  wire       run,
  input  wire       restart,
  input  wire [2:0] div_select,
  output reg        tick
);

  reg  [6:0] count;
  reg  [6:0] mask;

  // Codes 0 and 1 both divide by two
  always @*
  begin
    case (div_select)
      3'h0:    mask = 7'h01;
      3'h1:    mask = 7'h01;
      3'h2:    mask = 7'h03;
      3'h3:    mask = 7'h07;
      3'h4:    mask = 7'h0F;
      3'h5:    mask = 7'h1F;
      3'h6:    mask = 7'h3F;
      default: mask = 7'h7F;
    endcase
  end

  always @(posedge core_clk)
  begin
    if (!rst_n || !run || restart)
    begin
      count <= 7'h00;
      tick  <= 1'b0;
    end
    else
    begin
      count <= count + 7'h01;
      tick  <= ((count & mask) == mask);
    end
  end

endmodule // adccf_prescaler

/* hdl/adccf_top.v */
// The strobed register port is this design's own decision.
`timescale 1ns/1ns
`include "adccf_map.vh"

// Summary of operation
// - Single-ended code clamps to 0..3FF unsigned
// - Unipolar differential clamps negative to zero
// - Bipolar mode only when bipolar select set
// - Bipolar halves difference, two's complement range
// - Bit 9 in high byte is sign
// - Channel all ones enables temperature sensor
// - Result registers update at completion flag
// - Enable bit 7 turns converter on/off
// - Clearing enable aborts running conversion
// - Writing start bit begins a conversion
// - First conversion after enable takes 25 cycles
// - Start bit reads one while converting
// - Writing zero to start is ignored
// - Auto trigger enable uses selected source
// - Rising trigger edge starts a conversion
// - Done flag set at completion, cleared by one
// - Prescaler divides system clock by 2..128
// - Left-align changes presented data immediately
// - Low byte read locks result until high read
module adccf_top
(
  input  wire        core_clk,
  input  wire        rst_n,
  input  wire [7:0]  reg_addr,
  input  wire [7:0]  reg_wdata,
  input  wire        reg_write,
  input  wire        reg_read,
  output reg  [7:0]  reg_rdata,
  input  wire        irq_ack,
  input  wire [7:0]  trigger_in,
  input  wire [11:0] analog_value,
  input  wire        channel_is_diff,
  output reg         conv_irq,
  output reg         converter_on,
  output reg         sample_start,
  output reg         long_conversion,
  output reg  [5:0]  channel_select,
  output reg         bipolar_mode,
  output reg         temp_sensor_enable
);

  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_WAIT = 2'h1;
  localparam [1:0] ST_CONV = 2'h2;

  // control_status_a fields
  reg        converter_enable;
  reg        start_conversion;
  reg        auto_trigger_enable;
  reg        conversion_done_flag;
  reg        done_irq_enable;
  reg  [2:0] clock_divider_select;

  // control_status_b and mux_select_reg
  reg        bipolar_select;
  reg        chan_msb;
  reg  [2:0] trigger_source_select;
  reg  [7:0] mux_select_reg;

  reg  [1:0] state;
  reg  [4:0] cycle_count;
  reg  [4:0] conv_length;
  reg        first_pending;
  reg        result_locked;
  reg  [9:0] result_word;
  reg        trig_prev;

  wire       conv_tick;
  wire       left_align;
  wire [5:0] channel_gain_select;
  wire       wr_ctrl_a;
  wire       wr_ctrl_b;
  wire       wr_mux;
  wire       rd_low;
  wire       rd_high;
  wire       trig_level;
  wire       trig_edge;
  wire       free_running;
  wire       sw_start;
  wire       auto_start;
  wire       enable_off;
  wire       conv_complete;
  wire       next_enable;
  wire       flag_clear;

  reg  [9:0] formatted;
  reg  [11:0] half_value;
  reg  [7:0] pres_low;
  reg  [7:0] pres_high;
  reg  [7:0] next_rdata;

  assign left_align          = mux_select_reg[`ADCCF_M_LEFT_ALIGN];
  assign channel_gain_select = {chan_msb, mux_select_reg[`ADCCF_M_CHAN_HI:`ADCCF_M_CHAN_LO]};

  assign wr_ctrl_a = reg_write && (reg_addr == `ADCCF_OFS_CTRL_A);
  assign wr_ctrl_b = reg_write && (reg_addr == `ADCCF_OFS_CTRL_B);
  assign wr_mux    = reg_write && (reg_addr == `ADCCF_OFS_MUX_SELECT);
  assign rd_low    = reg_read && (reg_addr == `ADCCF_OFS_RESULT_LOW);
  assign rd_high   = reg_read && (reg_addr == `ADCCF_OFS_RESULT_HIGH);

  assign next_enable = wr_ctrl_a ? reg_wdata[`ADCCF_A_ENABLE] : converter_enable;
  assign enable_off  = wr_ctrl_a && !reg_wdata[`ADCCF_A_ENABLE];

  // A written zero never reaches the start logic
  assign sw_start = wr_ctrl_a && reg_wdata[`ADCCF_A_START] && next_enable;

  // Inputs are synchronous, so the edge is taken directly
  assign trig_level   = trigger_in[trigger_source_select];
  assign trig_edge    = trig_level && !trig_prev;
  assign free_running = auto_trigger_enable &&
                        (trigger_source_select == `ADCCF_TRIG_FREE_RUN);
  assign auto_start   = auto_trigger_enable && converter_enable && !free_running &&
                        trig_edge && (state == ST_IDLE) && !enable_off;

  assign conv_complete = (state == ST_CONV) && conv_tick &&
                         (cycle_count == conv_length - 5'h01);

  assign flag_clear = (wr_ctrl_a && reg_wdata[`ADCCF_A_DONE]) || irq_ack;

  // Trigger restarts the prescaler for a fixed trigger-to-sample delay
  adccf_prescaler u_prescaler
  (
    .core_clk   (core_clk),
    .rst_n      (rst_n),
    .run        (converter_enable),
    .restart    (auto_start),
    .div_select (clock_divider_select),
    .tick       (conv_tick)
  );

  // Raw value is the difference scaled by 1024 over reference, gain applied
  always @*
  begin
    half_value = {analog_value[11], analog_value[11:1]};
    if (bipolar_select && channel_is_diff)
    begin
      if (half_value[11:9] == 3'b000 || half_value[11:9] == 3'b111)
        formatted = half_value[9:0];
      else if (half_value[11])
        formatted = `ADCCF_BIP_MIN;
      else
        formatted = `ADCCF_BIP_MAX;
    end
    else if (analog_value[11])
      formatted = `ADCCF_CODE_MIN;
    else if (analog_value[10])
      formatted = `ADCCF_CODE_MAX;
    else
      formatted = analog_value[9:0];
  end

  // Alignment is applied at read time so a change shows at once
  always @*
  begin
    if (left_align)
    begin
      pres_high = result_word[9:2];
      pres_low  = {result_word[1:0], 6'h00};
    end
    else
    begin
      pres_high = {6'h00, result_word[9:8]};
      pres_low  = result_word[7:0];
    end
  end

  always @*
  begin
    case (reg_addr)
      `ADCCF_OFS_RESULT_LOW:  next_rdata = pres_low;
      `ADCCF_OFS_RESULT_HIGH: next_rdata = pres_high;
      `ADCCF_OFS_CTRL_A:      next_rdata = {converter_enable, start_conversion,
                                            auto_trigger_enable, conversion_done_flag,
                                            done_irq_enable, clock_divider_select};
      `ADCCF_OFS_CTRL_B:      next_rdata = {bipolar_select, 3'h0, chan_msb,
                                            trigger_source_select};
      `ADCCF_OFS_MUX_SELECT:  next_rdata = mux_select_reg;
      default:                next_rdata = 8'h00;
    endcase
  end

  always @(posedge core_clk)
  begin
    if (!rst_n)
      reg_rdata <= 8'h00;
    else if (reg_read)
      reg_rdata <= next_rdata;
    else
      reg_rdata <= 8'h00;
  end

  // Plain configuration registers
  always @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      auto_trigger_enable   <= 1'b0;
      done_irq_enable       <= 1'b0;
      clock_divider_select  <= 3'h0;
      bipolar_select        <= 1'b0;
      chan_msb              <= 1'b0;
      trigger_source_select <= 3'h0;
      mux_select_reg        <= `ADCCF_RST_MUX;
      trig_prev             <= 1'b0;
    end
    else
    begin
      trig_prev <= trig_level;
      if (wr_ctrl_a)
      begin
        auto_trigger_enable  <= reg_wdata[`ADCCF_A_AUTO];
        done_irq_enable      <= reg_wdata[`ADCCF_A_IRQ_EN];
        clock_divider_select <= reg_wdata[`ADCCF_A_DIV_HI:`ADCCF_A_DIV_LO];
      end
      if (wr_ctrl_b)
      begin
        bipolar_select        <= reg_wdata[`ADCCF_B_BIPOLAR];
        chan_msb              <= reg_wdata[`ADCCF_B_CHAN_HI];
        trigger_source_select <= reg_wdata[`ADCCF_B_TRIG_HI:`ADCCF_B_TRIG_LO];
      end
      if (wr_mux)
        mux_select_reg <= reg_wdata;
    end
  end

  // Conversion sequencer
  always @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      converter_enable <= 1'b0;
      start_conversion <= 1'b0;
      first_pending    <= 1'b0;
      state            <= ST_IDLE;
      cycle_count      <= 5'h00;
      conv_length      <= `ADCCF_CYC_NORMAL;
      sample_start     <= 1'b0;
      long_conversion  <= 1'b0;
    end
    else
    begin
      sample_start <= 1'b0;
      if (wr_ctrl_a)
        converter_enable <= reg_wdata[`ADCCF_A_ENABLE];
      if (wr_ctrl_a && reg_wdata[`ADCCF_A_ENABLE] && !converter_enable)
        first_pending <= 1'b1;
      if (enable_off)
      begin
        state            <= ST_IDLE;
        start_conversion <= 1'b0;
        long_conversion  <= 1'b0;
      end
      else
      begin
        case (state)
          ST_IDLE:
          begin
            if (sw_start || auto_start)
            begin
              start_conversion <= 1'b1;
              state            <= ST_WAIT;
            end
          end
          ST_WAIT:
          begin
            if (conv_tick)
            begin
              state        <= ST_CONV;
              cycle_count  <= 5'h00;
              sample_start <= 1'b1;
              // Start written with enable still gets the long conversion
              if (first_pending || (wr_ctrl_a && !converter_enable))
              begin
                conv_length     <= `ADCCF_CYC_FIRST;
                long_conversion <= 1'b1;
                first_pending   <= 1'b0;
              end
              else
              begin
                conv_length     <= `ADCCF_CYC_NORMAL;
                long_conversion <= 1'b0;
              end
            end
          end
          ST_CONV:
          begin
            if (conv_tick)
              cycle_count <= cycle_count + 5'h01;
            if (conv_complete)
            begin
              long_conversion <= 1'b0;
              if (free_running)
                state <= ST_WAIT;
              else
              begin
                state            <= ST_IDLE;
                start_conversion <= 1'b0;
              end
            end
          end
          default:
          begin
            state <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // Result, read lock and completion flag
  always @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      result_word          <= `ADCCF_RST_RESULT;
      result_locked        <= 1'b0;
      conversion_done_flag <= 1'b0;
    end
    else
    begin
      if (rd_low)
        result_locked <= 1'b1;
      else if (rd_high)
        result_locked <= 1'b0;
      // Completion while locked drops the sample rather than tearing it
      if (conv_complete && !result_locked)
        result_word <= formatted;
      // Set beats a clear arriving in the same cycle
      if (conv_complete)
        conversion_done_flag <= 1'b1;
      else if (flag_clear)
        conversion_done_flag <= 1'b0;
    end
  end

  // Outputs toward the analog core and the interrupt controller
  always @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      conv_irq           <= 1'b0;
      converter_on       <= 1'b0;
      channel_select     <= 6'h00;
      bipolar_mode       <= 1'b0;
      temp_sensor_enable <= 1'b0;
    end
    else
    begin
      conv_irq     <= conversion_done_flag && done_irq_enable;
      converter_on <= converter_enable;
      bipolar_mode <= bipolar_select;
      // Selection frozen while converting so the input stays settled
      if (state != ST_CONV || conv_complete)
      begin
        channel_select     <= channel_gain_select;
        temp_sensor_enable <= (channel_gain_select == `ADCCF_TEMP_CHANNEL);
      end
    end
  end

endmodule // adccf_top

/* tb/adccf_checker.sv */
`timescale 1ns/1ns
module adccf_checker
(
  input wire        core_clk,
  input wire        rst_n,
  input wire [7:0]  reg_addr,
  input wire [7:0]  reg_wdata,
  input wire        reg_write,
  input wire        reg_read,
  input wire [7:0]  reg_rdata,
  input wire        irq_ack,
  input wire [7:0]  trigger_in,
  input wire [11:0] analog_value,
  input wire        channel_is_diff,
  input wire        conv_irq,
  input wire        converter_on,
  input wire        sample_start,
  input wire        long_conversion,
  input wire [5:0]  channel_select,
  input wire        bipolar_mode,
  input wire        temp_sensor_enable
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  wire wr_a = reg_write && reg_addr == 8'h06;
  wire wr_b = reg_write && reg_addr == 8'h03;
  // Lone writes only, so a one or two cycle copy lag both pass
  property p_enable;
    wr_a ##1 !wr_a |=> converter_on == $past(reg_wdata[7], 2);
  endproperty
  a_enable: assert property (p_enable) else $error("enable copy wrong");
  property p_bipolar;
    wr_b ##1 !wr_b |=> bipolar_mode == $past(reg_wdata[7], 2);
  endproperty
  a_bipolar: assert property (p_bipolar) else $error("bipolar copy wrong");
  property p_abort;
    $fell(converter_on) |-> !sample_start [*4];
  endproperty
  a_abort: assert property (p_abort) else $error("start after disable");
  property p_irq_off;
    wr_a && !reg_wdata[3] |-> ##2 !conv_irq;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("irq while masked");
  property p_start_on;
    sample_start |-> converter_on;
  endproperty
  a_start_on: assert property (p_start_on) else $error("start while off");
  property p_start_gap;
    sample_start |=> !sample_start [*8];
  endproperty
  a_start_gap: assert property (p_start_gap) else $error("starts too close");
  property p_temp;
    temp_sensor_enable == (channel_select == 6'h3F);
  endproperty
  a_temp: assert property (p_temp) else $error("sensor enable wrong");
  property p_keep;
    wr_a && reg_wdata[7] && !reg_wdata[6] && long_conversion |=> converter_on;
  endproperty
  a_keep: assert property (p_keep) else $error("zero start disturbed");
  c_long: cover property (sample_start && long_conversion);
  c_irq: cover property ($rose(conv_irq));
  c_temp: cover property (temp_sensor_enable);
endmodule // adccf_checker

bind adccf_top adccf_checker u_chk
(
  .core_clk           (core_clk),
  .rst_n              (rst_n),
  .reg_addr           (reg_addr),
  .reg_wdata          (reg_wdata),
  .reg_write          (reg_write),
  .reg_read           (reg_read),
  .reg_rdata          (reg_rdata),
  .irq_ack            (irq_ack),
  .trigger_in         (trigger_in),
  .analog_value       (analog_value),
  .channel_is_diff    (channel_is_diff),
  .conv_irq           (conv_irq),
  .converter_on       (converter_on),
  .sample_start       (sample_start),
  .long_conversion    (long_conversion),
  .channel_select     (channel_select),
  .bipolar_mode       (bipolar_mode),
  .temp_sensor_enable (temp_sensor_enable)
);

/* tb/adccf_core_model.sv */
`timescale 1ns/1ns
module adccf_core_model
(
  input  wire        core_clk,
  input  wire        sample_start,
  input  wire [11:0] set_value,
  input  wire        set_diff,
  output reg  [11:0] analog_value = 12'h000,
  output wire        channel_is_diff
);
  assign channel_is_diff = set_diff;
  // Held from sample point; later changes of the input do not leak in
  always @(posedge core_clk)
    if (sample_start)
      analog_value <= set_value;
endmodule // adccf_core_model

/* tb/tb.sv */
`timescale 1ns/1ns
module tb;
  reg         core_clk;
  reg         rst_n;
  reg  [7:0]  reg_addr;
  reg  [7:0]  reg_wdata;
  reg         reg_write;
  reg         reg_read;
  reg         irq_ack;
  reg  [7:0]  trigger_in;
  reg  [11:0] set_value;
  reg         set_diff;
  wire [7:0]  reg_rdata;
  wire [11:0] analog_value;
  wire        channel_is_diff;
  wire        conv_irq;
  wire        converter_on;
  wire        sample_start;
  wire        long_conversion;
  wire [5:0]  channel_select;
  wire        bipolar_mode;
  wire        temp_sensor_enable;
  reg  [7:0]  d;
  integer     n_mismatch;
  integer     samples_checked;
  integer     i;
  integer     n;
  integer     dv;
  typedef struct packed {logic [11:0] v; logic df; logic bp; logic la; logic [15:0] r;} adccf_row;
  adccf_row   rows [0:7];

  adccf_top dut
  (
    .core_clk           (core_clk),
    .rst_n              (rst_n),
    .reg_addr           (reg_addr),
    .reg_wdata          (reg_wdata),
    .reg_write          (reg_write),
    .reg_read           (reg_read),
    .reg_rdata          (reg_rdata),
    .irq_ack            (irq_ack),
    .trigger_in         (trigger_in),
    .analog_value       (analog_value),
    .channel_is_diff    (channel_is_diff),
    .conv_irq           (conv_irq),
    .converter_on       (converter_on),
    .sample_start       (sample_start),
    .long_conversion    (long_conversion),
    .channel_select     (channel_select),
    .bipolar_mode       (bipolar_mode),
    .temp_sensor_enable (temp_sensor_enable)
  );
  adccf_core_model u_core (.core_clk(core_clk), .sample_start(sample_start),
    .set_value(set_value), .set_diff(set_diff), .analog_value(analog_value),
    .channel_is_diff(channel_is_diff));

  initial
  begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  task chk(input string nm, input [7:0] e, input [7:0] g);
  begin
    samples_checked = samples_checked + 1;
    if (g !== e)
    begin
      n_mismatch = n_mismatch + 1;
      $display("ERROR %s exp %h got %h", nm, e, g);
    end
  end
  endtask

  task wr(input [7:0] a, input [7:0] v);
  begin
    @(posedge core_clk);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge core_clk);
    reg_write <= 1'b0;
  end
  endtask

  task rd(input [7:0] a);
  begin
    @(posedge core_clk);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_read <= 1'b0;
    #1 d = reg_rdata;
  end
  endtask

  // Bounded wait for start pulse (0) or irq (1); n holds cycles
  task wait_on(input bit irq);
  begin
    n = 0;
    while ((irq ? conv_irq : sample_start) !== 1'b1 && n < 20000)
    begin
      @(posedge core_clk);
      #1 n = n + 1;
    end
    // A hang ends the run as a failure
    if (n >= 20000)
    begin
      n_mismatch = n_mismatch + 1;
      $display("ERROR wait_on exp %0d got timeout", irq);
      conclude;
    end
  end
  endtask

  task conclude;
  begin
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  end
  endtask

  initial
  begin
    #320000;
    n_mismatch = n_mismatch + 1;
    conclude;
  end

  initial
  begin
    {rst_n, reg_write, reg_read, irq_ack, set_diff} = 5'h00;
    {reg_addr, reg_wdata, trigger_in, set_value} = 36'h0;
    n_mismatch = 0;
    samples_checked = 0;
    rows[0] = {12'h155, 3'b000, 16'h0155};
    rows[1] = {12'h500, 3'b000, 16'h03FF};
    rows[2] = {12'hFFB, 3'b100, 16'h0000};
    rows[3] = {12'hFFB, 3'b110, 16'h03FD};
    rows[4] = {12'h7FF, 3'b110, 16'h01FF};
    rows[5] = {12'h800, 3'b110, 16'h0200};
    rows[6] = {12'h155, 3'b001, 16'h5540};
    rows[7] = {12'hFFB, 3'b010, 16'h0000};
    repeat (20) @(posedge core_clk);
    rst_n <= 1'b1;
    // Each divider code; code 0 also the first, long conversion
    for (i = 0; i < 8; i = i + 1)
    begin
      dv = (i < 2) ? 2 : (1 << i);
      wr(8'h06, {5'b11001, i[2:0]});
      wait_on(0);
      wait_on(1);
      dv = (i == 0) ? 2 * dv : dv;
      chk("cycles", 8'h01, {7'h0, n >= 12 * dv && n <= 13 * dv + 4});
      wr(8'h06, {5'b10011, i[2:0]});
    end
    for (i = 0; i < 8; i = i + 1)
    begin
      set_value <= rows[i].v;
      set_diff <= rows[i].df;
      wr(8'h03, {rows[i].bp, 7'h00});
      wr(8'h07, 8'h00);
      wr(8'h06, 8'hC8);
      wait_on(1);
      rd(8'h06);
      chk("status", 8'h98, d);
      wr(8'h07, {2'b00, rows[i].la, 5'h00});
      rd(8'h04);
      chk("low", rows[i].r[7:0], d);
      rd(8'h05);
      chk("high", rows[i].r[15:8], d);
      wr(8'h06, 8'h98);
      rd(8'h06);
      chk("cleared", 8'h88, d);
    end
    // Low read holds the result until high is read
    {set_value, set_diff} <= 13'h0154;
    wr(8'h03, 8'h00);
    wr(8'h07, 8'h00);
    wr(8'h06, 8'hC8);
    wait_on(1);
    rd(8'h04);
    @(posedge core_clk);
    irq_ack <= 1'b1;
    @(posedge core_clk);
    irq_ack <= 1'b0;
    rd(8'h06);
    chk("ack", 8'h88, d);
    set_value <= 12'h155;
    wr(8'h06, 8'hC8);
    wait_on(1);
    rd(8'h05);
    chk("locked", 8'h00, d);
    rd(8'h04);
    chk("dropped", 8'hAA, d);
    // Flag of the dropped sample is still set; clear it with this start
    wr(8'h06, 8'hD8);
    wait_on(0);
    wr(8'h06, 8'h00);
    rd(8'h06);
    chk("abort", 8'h00, d);
    repeat (80) @(posedge core_clk);
    rd(8'h06);
    chk("no flag", 8'h00, d);
    wr(8'h06, 8'hC8);
    wait_on(0);
    chk("long", 8'h01, {7'h0, long_conversion});
    wr(8'h06, 8'h88);
    rd(8'h06);
    chk("busy", 8'hC8, d);
    wait_on(1);
    chk("zero start", 8'h01, {7'h0, n < 100});
    wr(8'h06, 8'h98);
    wr(8'h03, 8'h01);
    wr(8'h06, 8'hA8);
    trigger_in <= 8'h02;
    wait_on(0);
    chk("trigger", 8'h01, {7'h0, n < 12});
    wait_on(1);
    trigger_in <= 8'h00;
    wr(8'h06, 8'hB8);
    wr(8'h03, 8'h00);
    wr(8'h06, 8'hE8);
    wait_on(1);
    wait_on(0);
    chk("free run", 8'h01, {7'h0, n < 8});
    rd(8'h06);
    chk("free start", 8'h01, {7'h0, d[6]});
    wr(8'h06, 8'h18);
    // Temperature channel: chan_msb and the mux channel field all ones
    wr(8'h07, 8'h9F);
    wr(8'h03, 8'h08);
    repeat (3) @(posedge core_clk);
    chk("temp", 8'h7F, {1'b0, temp_sensor_enable, channel_select});
    wr(8'h03, 8'h00);
    repeat (3) @(posedge core_clk);
    chk("no temp", 8'h1F, {1'b0, temp_sensor_enable, channel_select});
    rd(8'h10);
    chk("unmapped", 8'h00, d);
    rst_n <= 1'b0;
    repeat (20) @(posedge core_clk);
    rst_n <= 1'b1;
    for (i = 3; i < 8; i = i + 1)
    begin
      rd(i[7:0]);
      chk("reset", 8'h00, d);
    end
    conclude;
  end
endmodule // tb
